// ==== rtl/srd_map.svh ====
// Constants for the subroutine return decoder: opcode patterns, reset values and phase timing.
// Contract
// - Plain return opcode pops the return stack; popped entry becomes next program address.
// - Plain return loads program counter from top-of-stack entry, resuming after the call.
// - Returns take two instruction cycles; pop in fourth quarter phase; second cycle idle.
// - Literal return writes its 8-bit immediate to accumulator and pops stack in fourth quarter.
`ifndef SRD_MAP_SVH
`define SRD_MAP_SVH

// ****************************************************************
// Opcode patterns.
// ****************************************************************
`define SRD_OP_RETURN     14'h0008
`define SRD_OP_LIT_MASK   14'h3C00
`define SRD_OP_LIT_VALUE  14'h3400

// ****************************************************************
// Quarter phase timing and reset values.
// ****************************************************************
`define SRD_CLK_PERIOD_NS 5
`define SRD_QUARTER_NS    5
`define SRD_QUARTER_CYC   ((`SRD_QUARTER_NS + `SRD_CLK_PERIOD_NS - 1) / `SRD_CLK_PERIOD_NS)
`define SRD_RESET_ACC     8'h00
`define SRD_RESET_PROG_CNT 13'h0000

`endif

// ==== rtl/srd_pkg.sv ====
// Types shared by the subroutine return decoder.
package srd_pkg;
  typedef enum logic [1:0] {
    SRD_PHASE1,
    SRD_PHASE2,
    SRD_PHASE3,
    SRD_PHASE4
  } srd_phase_e;

  typedef enum logic [1:0] {
    SRD_IDLE,
    SRD_FIRST_RET,
    SRD_FIRST_LIT,
    SRD_SECOND
  } srd_state_e;
endpackage

// ==== rtl/srd_return_decode.sv ====
// Decoder and sequencer for the plain return and the literal return instructions.
`include "srd_map.svh"

module srd_return_decode #(
  parameter int PC_W = 13,
  parameter int OP_W = 14
) (
  input  wire logic            clk,              // System clock.
  input  wire logic            reset,            // Synchronous reset, active high.
  input  wire logic            fetchValid,       // Opcode valid, sampled at fourth quarter phase.
  input  wire logic [OP_W-1:0] opcode,           // Fetched instruction word.
  input  wire logic [PC_W-1:0] topOfStackEntry,  // Current return stack top.
  output logic      [1:0]      quarterPhase,     // Current quarter phase, 0 is Q1.
  output logic                 fourthQuarterPhase, // High during the fourth quarter phase.
  output logic                 stackPop,         // One-cycle pop strobe.
  output logic                 pcLoad,           // One-cycle program counter load strobe.
  output logic      [PC_W-1:0] programCounter,   // Program counter value.
  output logic                 accWrite,         // One-cycle accumulator write strobe.
  output logic      [7:0]      accumulator,      // Working accumulator value.
  output logic                 busy,             // High while a return is executing.
  output logic                 statusWrite       // Status flag write, held low.
);

  // ****************************************************************
  // Decode functions.
  // ****************************************************************
  function automatic logic isReturn(input logic [OP_W-1:0] op);
    isReturn = (op == OP_W'(`SRD_OP_RETURN));
  endfunction

  function automatic logic isLitReturn(input logic [OP_W-1:0] op);
    isLitReturn = ((op & OP_W'(`SRD_OP_LIT_MASK)) == OP_W'(`SRD_OP_LIT_VALUE));
  endfunction

  // ****************************************************************
  // Quarter phase generator and sequencer.
  // ****************************************************************
  srd_pkg::srd_phase_e phase_reg, phase_next;
  srd_pkg::srd_state_e state_reg, state_next;
  logic [7:0]      lit_reg, lit_next;
  logic [PC_W-1:0] progCnt_reg, progCnt_next;
  logic [7:0]      acc_reg, acc_next;
  logic            pop_reg, pop_next;
  logic            accWr_reg, accWr_next;
  logic            lastQuarter;

  // Opcodes are only looked at in the last quarter, when the fetch side has a whole word ready.
  assign lastQuarter = (phase_reg == srd_pkg::SRD_PHASE4);

  always_comb begin
    phase_next   = srd_pkg::srd_phase_e'(phase_reg + 2'h1);
    state_next   = state_reg;
    lit_next     = lit_reg;
    progCnt_next = progCnt_reg;
    acc_next     = acc_reg;
    pop_next     = 1'b0;
    accWr_next   = 1'b0;
    case (state_reg)
      srd_pkg::SRD_IDLE: begin
        if (lastQuarter && fetchValid) begin
          if (isReturn(opcode)) begin
            state_next = srd_pkg::SRD_FIRST_RET;
          end else if (isLitReturn(opcode)) begin
            state_next = srd_pkg::SRD_FIRST_LIT;
            lit_next   = opcode[7:0];
          end
        end
      end
      // The strobes are set up in the third quarter so that they stand during the fourth.
      srd_pkg::SRD_FIRST_RET, srd_pkg::SRD_FIRST_LIT: begin
        if (phase_reg == srd_pkg::SRD_PHASE3) begin
          pop_next     = 1'b1;
          progCnt_next = topOfStackEntry;
          if (state_reg == srd_pkg::SRD_FIRST_LIT) begin
            acc_next   = lit_reg;
            accWr_next = 1'b1;
          end
        end
        if (lastQuarter) begin
          state_next = srd_pkg::SRD_SECOND;
        end
      end
      // The second cycle does nothing; a word offered during it is refused.
      srd_pkg::SRD_SECOND: begin
        if (lastQuarter) begin
          state_next = srd_pkg::SRD_IDLE;
        end
      end
      default: begin
        state_next = srd_pkg::SRD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_reg   <= srd_pkg::SRD_PHASE1;
      state_reg   <= srd_pkg::SRD_IDLE;
      lit_reg     <= 8'h00;
      progCnt_reg <= PC_W'(`SRD_RESET_PROG_CNT);
      acc_reg     <= `SRD_RESET_ACC;
      pop_reg     <= 1'b0;
      accWr_reg   <= 1'b0;
    end else begin
      phase_reg   <= phase_next;
      state_reg   <= state_next;
      lit_reg     <= lit_next;
      progCnt_reg <= progCnt_next;
      acc_reg     <= acc_next;
      pop_reg     <= pop_next;
      accWr_reg   <= accWr_next;
    end
  end

  // ****************************************************************
  // Registered outputs.
  // ****************************************************************
  logic fq_reg, fq_next;
  logic busy_reg, busy_next;
  logic statusWr_reg, statusWr_next;

  always_comb begin
    fq_next       = (phase_next == srd_pkg::SRD_PHASE4);
    busy_next     = (state_next != srd_pkg::SRD_IDLE);
    statusWr_next = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fq_reg       <= 1'b0;
      busy_reg     <= 1'b0;
      statusWr_reg <= 1'b0;
    end else begin
      fq_reg       <= fq_next;
      busy_reg     <= busy_next;
      statusWr_reg <= statusWr_next;
    end
  end

  assign quarterPhase       = phase_reg;
  assign fourthQuarterPhase = fq_reg;
  assign stackPop           = pop_reg;
  assign pcLoad             = pop_reg;
  assign programCounter     = progCnt_reg;
  assign accWrite           = accWr_reg;
  assign accumulator        = acc_reg;
  assign busy               = busy_reg;
  assign statusWrite        = statusWr_reg;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  // The phase step property skips the first edge after reset, where the past is reset state.
  a_pop_in_fourth: assert property (@(posedge clk) disable iff (reset)
    stackPop |-> fourthQuarterPhase && quarterPhase == 2'h3)
    else $error("Stack pop outside fourth quarter phase.");

  a_ret_pops: assert property (@(posedge clk) disable iff (reset)
    (lastQuarter && fetchValid && !busy && isReturn(opcode)) |-> ##4 stackPop)
    else $error("Plain return did not pop.");

  a_load_from_top: assert property (@(posedge clk) disable iff (reset)
    (busy && phase_reg == srd_pkg::SRD_PHASE3 && state_reg != srd_pkg::SRD_SECOND)
      |=> pcLoad && programCounter == $past(topOfStackEntry))
    else $error("Program counter not loaded from stack top.");

  a_lit_write: assert property (@(posedge clk) disable iff (reset)
    (lastQuarter && fetchValid && !busy && isLitReturn(opcode))
      |-> ##4 (accWrite && stackPop && accumulator == $past(opcode[7:0], 4)))
    else $error("Literal return did not load accumulator.");

  a_second_idle: assert property (@(posedge clk) disable iff (reset)
    (stackPop) |-> ##1 (!stackPop && !accWrite) [*4] ##1 !busy)
    else $error("Second cycle not idle or return too long.");

  a_no_status: assert property (@(posedge clk) disable iff (reset)
    !statusWrite)
    else $error("Status written by return.");

  a_plain_no_acc: assert property (@(posedge clk) disable iff (reset)
    (state_reg == srd_pkg::SRD_FIRST_RET) |-> !accWr_next)
    else $error("Plain return wrote accumulator.");

  a_acc_stable: assert property (@(posedge clk) disable iff (reset)
    !accWrite |-> $stable(accumulator))
    else $error("Accumulator changed without write.");

  a_phase_step: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> quarterPhase == 2'($past(quarterPhase) + 2'h1))
    else $error("Quarter phase did not advance by one.");

  a_fourth_flag: assert property (@(posedge clk) disable iff (reset)
    fourthQuarterPhase == (quarterPhase == 2'h3))
    else $error("Fourth quarter flag does not match the phase.");

  a_busy_length: assert property (@(posedge clk) disable iff (reset)
    $rose(busy) |-> busy [*8] ##1 !busy)
    else $error("Return did not last exactly two instruction cycles.");

  a_lit_dont_care: assert property (@(posedge clk) disable iff (reset)
    (lastQuarter && fetchValid && !busy && opcode[OP_W-1:OP_W-4] == 4'hD)
      |=> busy && state_reg == srd_pkg::SRD_FIRST_LIT)
    else $error("Literal return with ignored bits set was not taken.");

  a_other_ignored: assert property (@(posedge clk) disable iff (reset)
    (lastQuarter && fetchValid && !busy && opcode != OP_W'(`SRD_OP_RETURN)
      && opcode[OP_W-1:OP_W-4] != 4'hD) |=> !busy)
    else $error("Opcode other than a return was taken.");

  a_pop_once: assert property (@(posedge clk) disable iff (reset)
    stackPop |=> !stackPop)
    else $error("Stack pop lasted more than one cycle.");

  a_count_hold: assert property (@(posedge clk) disable iff (reset)
    !pcLoad |-> $stable(programCounter))
    else $error("Program counter changed without load.");

  a_write_with_pop: assert property (@(posedge clk) disable iff (reset)
    accWrite |-> stackPop && state_reg == srd_pkg::SRD_FIRST_LIT)
    else $error("Accumulator written outside literal return pop.");

endmodule

// ==== tb/tb_srd_return_decode.sv ====
// Self-checking testbench for the subroutine return decoder.
module tb_srd_return_decode;
  timeunit 1ns;
  timeprecision 1ps;

  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, b); end end

  logic        clk;
  logic        reset;
  logic        fetchValid;
  logic [13:0] opcode;
  logic [12:0] topOfStackEntry;
  logic [1:0]  quarterPhase;
  logic        fourthQuarterPhase;
  logic        stackPop;
  logic        pcLoad;
  logic [12:0] programCounter;
  logic        accWrite;
  logic [7:0]  accumulator;
  logic        busy;
  logic        statusWrite;
  logic [12:0] expProgCnt;
  logic [7:0]  expAcc;
  int          err_total;
  int          checks_done;
  int          cycles;

  srd_return_decode srd_return_decode_i (
    .clk                (clk),
    .reset              (reset),
    .fetchValid         (fetchValid),
    .opcode             (opcode),
    .topOfStackEntry    (topOfStackEntry),
    .quarterPhase       (quarterPhase),
    .fourthQuarterPhase (fourthQuarterPhase),
    .stackPop           (stackPop),
    .pcLoad             (pcLoad),
    .programCounter     (programCounter),
    .accWrite           (accWrite),
    .accumulator        (accumulator),
    .busy               (busy),
    .statusWrite        (statusWrite)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // The opcode is held through both cycles, so every fourth phase while busy must be refused.
  task automatic runOp(input logic [13:0] op, input logic [12:0] topEntry, input logic take, input logic lit);
    int   k;
    logic hit;
    @(negedge clk);
    for (k = 0; k < 20 && !(quarterPhase === 2'h3 && busy === 1'b0); k++) @(negedge clk);
    fetchValid = 1'b1;
    opcode = op;
    topOfStackEntry = topEntry;
    for (k = 1; k <= 9; k++) begin
      @(negedge clk);
      hit = take && k == 4;
      if (hit) begin
        expProgCnt = topEntry;
        if (lit) expAcc = op[7:0];
      end
      `CHK(stackPop, hit)
      `CHK(pcLoad, hit)
      `CHK(accWrite, hit && lit)
      `CHK(programCounter, expProgCnt)
      `CHK(accumulator, expAcc)
      `CHK(busy, take && k <= 8)
      `CHK(statusWrite, 1'b0)
      `CHK(quarterPhase, 2'((k - 1) % 4))
      `CHK(fourthQuarterPhase, k % 4 == 0)
    end
    fetchValid = 1'b0;
  endtask

  task automatic testPlain();
    runOp(14'h0008, 13'h1ABC, 1'b1, 1'b0);
    runOp(14'h0008, 13'h0123, 1'b1, 1'b0);
  endtask

  // All four settings of the ignored bits must still decode as a literal return.
  task automatic testLiteral();
    runOp(14'h34FF, 13'h1FFF, 1'b1, 1'b1);
    runOp(14'h355A, 13'h0001, 1'b1, 1'b1);
    runOp(14'h36A5, 13'h0AAA, 1'b1, 1'b1);
    runOp(14'h3700, 13'h1555, 1'b1, 1'b1);
    runOp(14'h0008, 13'h0F0F, 1'b1, 1'b0);
  endtask

  // A reset in the second cycle of a literal return clears the sequencer and the working values.
  task automatic testReset();
    int k;
    @(negedge clk);
    for (k = 0; k < 20 && !(quarterPhase === 2'h3 && busy === 1'b0); k++) @(negedge clk);
    fetchValid = 1'b1;
    opcode = 14'h34C3;
    topOfStackEntry = 13'h0ABC;
    repeat (5) @(negedge clk);
    `CHK(accumulator, 8'hC3)
    `CHK(programCounter, 13'h0ABC)
    `CHK(busy, 1'b1)
    reset = 1'b1;
    fetchValid = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(busy, 1'b0)
    `CHK(accumulator, 8'h00)
    `CHK(programCounter, 13'h0000)
    `CHK(quarterPhase, 2'h0)
    `CHK(stackPop, 1'b0)
    reset = 1'b0;
    expProgCnt = 13'h0000;
    expAcc = 8'h00;
    @(negedge clk);
    `CHK(quarterPhase, 2'h1)
    `CHK(busy, 1'b0)
  endtask

  task automatic testIgnored();
    runOp(14'h0009, 13'h1111, 1'b0, 1'b0);
    runOp(14'h3800, 13'h1222, 1'b0, 1'b0);
    runOp(14'h0000, 13'h1333, 1'b0, 1'b0);
    runOp(14'h1008, 13'h1444, 1'b0, 1'b0);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      err_total++;
      results();
    end
  end

  initial begin
    reset = 1'b1;
    fetchValid = 1'b0;
    opcode = 14'h0000;
    topOfStackEntry = 13'h0000;
    expProgCnt = 13'h0000;
    expAcc = 8'h00;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    testPlain();
    testLiteral();
    testReset();
    testIgnored();
    results();
  end
endmodule
